// ### fpep_pkg.sv
// fpep_pkg: constants and carrier types for the flash program/erase
// protection and ram overlay block.
// assumes byte-wide registers reached over a plain address/strobe port.
package fpep_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h80;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h81;
  localparam logic [7:0] ADDR_ERASE_SEL_ONE = 8'h82;
  localparam logic [7:0] ADDR_ERASE_SEL_TWO = 8'h83;
  localparam logic [7:0] ADDR_RAM_OVERLAY = 8'h84;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // flash_ctrl_one / flash_ctrl_two share the low six positions
  localparam int BIT_PROGRAM_GO = 0;
  localparam int BIT_ERASE_GO = 1;
  localparam int BIT_PROGRAM_VERIFY = 2;
  localparam int BIT_ERASE_VERIFY = 3;
  localparam int BIT_PROGRAM_SETUP = 4;
  localparam int BIT_ERASE_SETUP = 5;
  localparam int BIT_SW_WRITE_ENABLE = 6;
  localparam int BIT_FLASH_ERROR = 7;
  // ram_overlay_ctrl
  localparam int BIT_OVERLAY_AREA_LO = 0;
  localparam int BIT_OVERLAY_AREA_HI = 1;
  localparam int BIT_EMULATION_SELECT = 2;

  // writable masks; everything else reads as zero, bar the error flag in bit 7 of flash_ctrl_two
  localparam logic [7:0] MASK_CTRL_ONE = 8'h7F;
  localparam logic [7:0] MASK_CTRL_TWO = 8'h3F;
  localparam logic [7:0] MASK_ERASE_SEL_ONE = 8'h0F;
  localparam logic [7:0] MASK_ERASE_SEL_TWO = 8'hFF;
  localparam logic [7:0] MASK_RAM_OVERLAY = 8'h07;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_ERASE_SEL = 8'h00;
  localparam logic [7:0] RST_RAM_OVERLAY = 8'h00;

  // ****************************************************************
  // erase block geometry
  // ****************************************************************
  localparam int NUM_BLOCKS = 12;
  localparam int BLOCKS_IN_ONE = 4;
  localparam logic [31:0] BLOCK_NINE_BASE = 32'h0003F000;
  localparam logic [31:0] SMALL_BLOCK_SIZE = 32'h00000400;
  localparam int FIRST_SMALL_BLOCK = 8;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic flashRead;
    logic exceptionTaken;
    logic sleepExec;
    logic busGranted;
  } fpep_cpu_evt_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } fpep_acc_req_t;

  typedef struct packed {
    logic valid;
    logic toRam;
    logic [31:0] addr;
  } fpep_acc_route_t;

endpackage

// ### fpep_ctrl.sv
// fpep_ctrl: program/erase protection, error latching and ram overlay
// for the on-chip flash array.
// assumes the cpu side reports its events as one-cycle pulses on the
// system clock and that register strobes never come together.
// outputs are registered, so every effect shows a cycle after its cause.
//
// Behaviour
// - write-protect pin high clears the four control registers; protected.
// - reset or standby initialises all four control registers; protected.
// - software write-enable at zero protects every block.
// - under software protection, program and erase bit writes are ignored.
// - erase reaches only blocks selected in the erase-select registers.
// - both erase-select registers zero means every block erase-protected.
// - emulation select at one protects all blocks regardless of area bits.
// - error sets the flag, aborts program/erase, keeps register contents.
// - while in error, program and erase bits cannot restart operations.
// - while in error, verify bits still take effect.
// - flash read during program/erase raises the error flag.
// - non-reset exception during program/erase raises the error flag.
// - sleep during program/erase raises the error flag.
// - bus grant to another master during program/erase raises the flag.
// - only reset or hardware standby clears the error flag.
// - overlay maps ram over the chosen block; both addresses reach ram.
// - overlay works in user mode and user program mode alike.
// - emulation select and area bits 1,0,1 overlay ram on block nine.
// - clearing emulation select returns the flash range to the array.
// - erase never reaches the overlaid area during emulation.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps

module fpep_ctrl
  import fpep_pkg::*;
#(
  parameter logic [31:0] OVERLAY_RAM_BASE = 32'hFFFFF000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // hardware protection sources
  input wire logic writeProtectPin,
  input wire logic swStandby,
  input wire logic hwStandby,
  // cpu events watched during program/erase
  input wire fpep_cpu_evt_t cpuEvt,
  // cpu access to be routed
  input wire fpep_acc_req_t accReq,
  output fpep_acc_route_t accRoute,
  // array control outputs
  output logic programOneEn,
  output logic programTwoEn,
  output logic [NUM_BLOCKS-1:0] eraseBlockEn,
  output logic programVerifyEn,
  output logic eraseVerifyEn,
  output logic flashErrorFlag,
  output logic overlayActive
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] flashCtrlOne;
  logic [5:0] flashCtrlTwo;
  logic [7:0] eraseSelectOne;
  logic [7:0] eraseSelectTwo;
  logic [2:0] ramOverlayCtrl;
  logic flashError;

  logic swWriteEnable;
  logic emulationSelect;
  logic [1:0] overlayArea;
  logic regInit;
  logic swProtect;
  logic goAllowed;
  logic wrCtrlOne;
  logic wrCtrlTwo;
  logic wrEraseOne;
  logic wrEraseTwo;
  logic wrOverlay;

  assign swWriteEnable = flashCtrlOne[BIT_SW_WRITE_ENABLE];
  assign emulationSelect = ramOverlayCtrl[BIT_EMULATION_SELECT];
  assign overlayArea = {ramOverlayCtrl[BIT_OVERLAY_AREA_HI],
                        ramOverlayCtrl[BIT_OVERLAY_AREA_LO]};

  // pin, reset and either standby all force the control registers home
  assign regInit = rst | writeProtectPin | swStandby
                 | hwStandby;

  // any software protection condition; the pin is here as well because in
  // the cycle it rises the registers still hold their old go bits
  assign swProtect = ~swWriteEnable | emulationSelect
                   | writeProtectPin;

  // go bits are accepted only outside protection and outside error
  assign goAllowed = ~swProtect & ~flashError;

  // strobes never coincide, so one decode per register is enough
  assign wrCtrlOne = regWr & (regAddr == ADDR_CTRL_ONE);
  assign wrCtrlTwo = regWr & (regAddr == ADDR_CTRL_TWO);
  assign wrEraseOne = regWr & (regAddr == ADDR_ERASE_SEL_ONE);
  assign wrEraseTwo = regWr & (regAddr == ADDR_ERASE_SEL_TWO);
  assign wrOverlay = regWr & (regAddr == ADDR_RAM_OVERLAY);

  // ****************************************************************
  // control register writes
  // ****************************************************************
  // go-bit filter: a refused go bit is stored as zero so a later lift of
  // protection cannot start an operation nobody asked for again
  function automatic logic [7:0] filterGo(input logic [7:0] wd,
                                          input logic allow);
    logic [7:0] res;
    res = wd;
    res[BIT_PROGRAM_GO] = wd[BIT_PROGRAM_GO] & allow;
    res[BIT_ERASE_GO] = wd[BIT_ERASE_GO] & allow;
    return res;
  endfunction

  always_ff @(posedge clock) begin
    if (regInit) begin
      flashCtrlOne <= RST_CTRL_ONE;
    end else if (wrCtrlOne) begin
      flashCtrlOne <= filterGo(regWrData, goAllowed) & MASK_CTRL_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (regInit) begin
      flashCtrlTwo <= RST_CTRL_TWO[5:0];
    end else if (wrCtrlTwo) begin
      flashCtrlTwo <= 6'(filterGo(regWrData, goAllowed)
                         & MASK_CTRL_TWO);
    end
  end

  // erase selects take any write, even under software protection; the go bits decide
  always_ff @(posedge clock) begin
    if (regInit) begin
      eraseSelectOne <= RST_ERASE_SEL;
    end else if (wrEraseOne) begin
      eraseSelectOne <= regWrData & MASK_ERASE_SEL_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (regInit) begin
      eraseSelectTwo <= RST_ERASE_SEL;
    end else if (wrEraseTwo) begin
      eraseSelectTwo <= regWrData & MASK_ERASE_SEL_TWO;
    end
  end

  // the overlay setting survives the pin and standby; only reset clears it
  always_ff @(posedge clock) begin
    if (rst) begin
      ramOverlayCtrl <= RST_RAM_OVERLAY[2:0];
    end else if (wrOverlay) begin
      ramOverlayCtrl <= 3'(regWrData & MASK_RAM_OVERLAY);
    end
  end

  // ****************************************************************
  // effective program / erase / verify
  // ****************************************************************
  logic programOne;
  logic programTwo;
  logic eraseOne;
  logic eraseTwo;
  logic opActive;
  logic [NUM_BLOCKS-1:0] blockSel;
  logic [NUM_BLOCKS-1:0] blockOverlaid;
  logic [NUM_BLOCKS-1:0] next_eraseBlockEn;
  logic [3:0] overlayBlock;

  // stored go bits act only while nothing protects them; error aborts
  // at once but leaves the stored settings untouched
  assign programOne = flashCtrlOne[BIT_PROGRAM_GO] & ~swProtect
                    & ~flashError;
  assign programTwo = flashCtrlTwo[BIT_PROGRAM_GO] & ~swProtect
                    & ~flashError;
  assign eraseOne = flashCtrlOne[BIT_ERASE_GO] & ~swProtect & ~flashError
                  & (|eraseSelectOne);
  assign eraseTwo = flashCtrlTwo[BIT_ERASE_GO] & ~swProtect & ~flashError
                  & (|eraseSelectTwo);

  // only a program or erase really in effect arms the error detector
  assign opActive = programOne | programTwo | eraseOne | eraseTwo;

  // area bits choose the small block overlaid; 01 is block nine
  always_comb begin
    case (overlayArea)
      2'h1: overlayBlock = 4'h8;
      2'h2: overlayBlock = 4'h9;
      2'h3: overlayBlock = 4'hA;
      2'h0: overlayBlock = 4'hB;
      default: overlayBlock = 4'hB;
    endcase
  end

  // blocks 0..3 sit in the first select register, the rest in the second
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BLOCKS; gb++) begin : g_block
      if (gb < BLOCKS_IN_ONE) begin : g_one
        assign blockSel[gb] = eraseSelectOne[gb] & eraseOne;
      end else begin : g_two
        assign blockSel[gb] = eraseSelectTwo[gb-BLOCKS_IN_ONE]
                            & eraseTwo;
      end
      assign blockOverlaid[gb] = emulationSelect
                               & (overlayBlock == 4'(gb));
      // belt and braces: the overlaid area is masked even if the
      // emulation protection were ever relaxed
      assign next_eraseBlockEn[gb] = blockSel[gb]
                                   & ~blockOverlaid[gb];
    end
  endgenerate

  // ****************************************************************
  // array control registers
  // ****************************************************************
  // one register per output, so each enable can be traced on its own
  always_ff @(posedge clock) begin
    if (rst) begin
      programOneEn <= 1'b0;
    end else begin
      programOneEn <= programOne;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      programTwoEn <= 1'b0;
    end else begin
      programTwoEn <= programTwo;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      eraseBlockEn <= '0;
    end else begin
      eraseBlockEn <= next_eraseBlockEn;
    end
  end

  // verify stays reachable in the error state
  always_ff @(posedge clock) begin
    if (rst) begin
      programVerifyEn <= 1'b0;
    end else begin
      programVerifyEn <= swWriteEnable & ~writeProtectPin
        & (flashCtrlOne[BIT_PROGRAM_VERIFY]
           | flashCtrlTwo[BIT_PROGRAM_VERIFY]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      eraseVerifyEn <= 1'b0;
    end else begin
      eraseVerifyEn <= swWriteEnable & ~writeProtectPin
        & (flashCtrlOne[BIT_ERASE_VERIFY]
           | flashCtrlTwo[BIT_ERASE_VERIFY]);
    end
  end

  // ****************************************************************
  // error protection
  // ****************************************************************
  logic errEvent;

  // the detector reads the live operation state, so an event in the very
  // cycle a go bit takes effect is already caught
  assign errEvent = opActive & (cpuEvt.flashRead
                              | cpuEvt.exceptionTaken
                              | cpuEvt.sleepExec
                              | cpuEvt.busGranted);

  // no register write reaches this flag; software standby keeps it
  always_ff @(posedge clock) begin
    if (rst | hwStandby) begin
      flashError <= 1'b0;
    end else if (errEvent) begin
      flashError <= 1'b1;
    end
  end

  // the event is folded in so the flag shows in the same cycle as the
  // abort; hardware standby wins over a late event
  always_ff @(posedge clock) begin
    if (rst) begin
      flashErrorFlag <= 1'b0;
    end else begin
      flashErrorFlag <= flashError | (errEvent & ~hwStandby);
    end
  end

  // ****************************************************************
  // ram overlay routing
  // ****************************************************************
  logic [31:0] overlayBase;
  logic [31:0] ramEnd;
  logic flashHit;
  logic ramHit;

  // the overlaid window follows the area code; code 01 is block nine
  assign overlayBase = BLOCK_NINE_BASE
    + 32'(overlayBlock - 4'(FIRST_SMALL_BLOCK)) * SMALL_BLOCK_SIZE;
  assign ramEnd = OVERLAY_RAM_BASE + SMALL_BLOCK_SIZE;
  // no mode qualifier: user mode and user program mode route alike
  assign flashHit = emulationSelect & (accReq.addr >= overlayBase)
                  & (accReq.addr < overlayBase
                     + SMALL_BLOCK_SIZE);
  // the ram window is plain ram and is reached with or without emulation
  assign ramHit = (accReq.addr >= OVERLAY_RAM_BASE)
                & (accReq.addr < ramEnd);

  always_ff @(posedge clock) begin
    if (rst) begin
      accRoute <= '0;
    end else begin
      accRoute.valid <= accReq.valid;
      accRoute.toRam <= flashHit | ramHit;
      accRoute.addr <= flashHit
        ? (OVERLAY_RAM_BASE | (accReq.addr & (SMALL_BLOCK_SIZE - 32'h1)))
        : accReq.addr;
    end
  end

  // mirrors the select bit a cycle late, in step with the routed accesses
  always_ff @(posedge clock) begin
    if (rst) begin
      overlayActive <= 1'b0;
    end else begin
      overlayActive <= emulationSelect;
    end
  end

  // ****************************************************************
  // register read-back
  // ****************************************************************
  logic [7:0] next_regRdData;

  // idle cycles and unmapped addresses read zero, so no state leaks out
  always_comb begin
    next_regRdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        ADDR_CTRL_ONE: next_regRdData = flashCtrlOne;
        ADDR_CTRL_TWO: next_regRdData = {flashError, 1'b0, flashCtrlTwo};
        ADDR_ERASE_SEL_ONE: next_regRdData = eraseSelectOne;
        ADDR_ERASE_SEL_TWO: next_regRdData = eraseSelectTwo;
        ADDR_RAM_OVERLAY: next_regRdData = {5'h00, ramOverlayCtrl};
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule

// ### fpep_ctrl_monitor.sv
// fpep_ctrl_monitor: port-level checks for the flash protection block.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps

module fpep_ctrl_monitor
  import fpep_pkg::*;
#(
  parameter logic [31:0] OVERLAY_RAM_BASE = 32'hFFFFF000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port and protection sources
  input wire logic regWr,
  input wire logic [7:0] regRdData,
  input wire logic writeProtectPin,
  input wire logic swStandby,
  input wire logic hwStandby,
  // cpu side
  input wire fpep_cpu_evt_t cpuEvt,
  input wire fpep_acc_req_t accReq,
  input wire fpep_acc_route_t accRoute,
  // array control
  input wire logic programOneEn,
  input wire logic programTwoEn,
  input wire logic [NUM_BLOCKS-1:0] eraseBlockEn,
  input wire logic flashErrorFlag,
  input wire logic overlayActive
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic quiet;
  logic quietPast;
  logic noWork;
  logic inNine;
  logic anyGo;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // outputs lag stored state by a cycle, so a write or a protection
  // source in the previous cycle may already have cancelled the operation
  assign quiet = !regWr && !writeProtectPin && !swStandby && !hwStandby;
  assign anyGo = programOneEn || programTwoEn || (|eraseBlockEn);
  assign noWork = !anyGo;
  assign inNine = accReq.valid && accReq.addr[31:10] == BLOCK_NINE_BASE[31:10];
  always_ff @(posedge clock) begin
    quietPast <= quiet && !rst;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> noWork && !flashErrorFlag && !overlayActive && regRdData == 8'h00)
    else $error("outputs not cleared by reset");
  pin_block_a: assert property (
    writeProtectPin [*2] |=> noWork)
    else $error("program or erase active under write protect");
  err_hold_a: assert property (
    flashErrorFlag && !hwStandby && !$past(hwStandby) |=> flashErrorFlag)
    else $error("error flag released without reset or standby");
  err_gate_a: assert property (
    flashErrorFlag [*2] |-> noWork)
    else $error("program or erase active in error state");
  err_set_a: assert property (
    anyGo && quiet && quietPast && (|cpuEvt) |=> flashErrorFlag)
    else $error("cpu event during operation did not set error");
  err_cause_a: assert property (
    $rose(flashErrorFlag) |-> $past(|cpuEvt))
    else $error("error flag rose without a cpu event");
  emu_block_a: assert property (
    overlayActive [*2] |-> noWork)
    else $error("program or erase active during emulation");
  ram_route_a: assert property (
    accReq.valid && accReq.addr[31:10] == OVERLAY_RAM_BASE[31:10]
    |=> accRoute.valid && accRoute.toRam)
    else $error("overlay ram access not routed to ram");
  overlay_off_a: assert property (
    inNine && !overlayActive ##1 !overlayActive |-> !accRoute.toRam)
    else $error("flash access routed to ram without emulation");
endmodule

bind fpep_ctrl fpep_ctrl_monitor #(
  .OVERLAY_RAM_BASE(OVERLAY_RAM_BASE)
) mon (
  .clock(clock), .rst(rst), .regWr(regWr), .regRdData(regRdData),
  .writeProtectPin(writeProtectPin), .swStandby(swStandby),
  .hwStandby(hwStandby), .cpuEvt(cpuEvt), .accReq(accReq),
  .accRoute(accRoute), .programOneEn(programOneEn),
  .programTwoEn(programTwoEn), .eraseBlockEn(eraseBlockEn),
  .flashErrorFlag(flashErrorFlag), .overlayActive(overlayActive)
);

// ### fpep_ctrl_tb.sv
// fpep_ctrl_tb: self-checking bench for the flash protection block.
// assumes the register port answers one cycle after each strobe.
`timescale 1ns/10ps

module fpep_ctrl_tb
  import fpep_pkg::*;
;
  localparam logic [31:0] RAM_BASE = 32'hFFFFF000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic writeProtectPin = 1'b0;
  logic swStandby = 1'b0;
  logic hwStandby = 1'b0;
  fpep_cpu_evt_t cpuEvt = '0;
  fpep_acc_req_t accReq = '0;
  fpep_acc_route_t accRoute;
  logic [7:0] regRdData;
  logic [NUM_BLOCKS-1:0] eraseBlockEn;
  logic programOneEn, programTwoEn, programVerifyEn;
  logic eraseVerifyEn, flashErrorFlag, overlayActive;
  int badCount = 0;
  int nChecks = 0;
  int cycles = 0;

  fpep_ctrl #(.OVERLAY_RAM_BASE(RAM_BASE)) uut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .writeProtectPin(writeProtectPin), .swStandby(swStandby),
    .hwStandby(hwStandby), .cpuEvt(cpuEvt), .accReq(accReq),
    .accRoute(accRoute), .programOneEn(programOneEn),
    .programTwoEn(programTwoEn), .eraseBlockEn(eraseBlockEn),
    .programVerifyEn(programVerifyEn), .eraseVerifyEn(eraseVerifyEn),
    .flashErrorFlag(flashErrorFlag), .overlayActive(overlayActive)
  );

  always #5 clock = ~clock;

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic reportAndStop();
    if (badCount == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic doReset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  task automatic acc(input logic [31:0] a, input logic e);
    @(posedge clock);
    accReq <= '{1'b1, a};
    @(posedge clock);
    accReq <= '0;
    #1;
    chk(accRoute.toRam, e);
  endtask

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      reportAndStop();
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    doReset();
    // five registers and one unmapped address
    for (int i = 0; i < 6; i++) rd(ADDR_CTRL_ONE + 8'(i), 8'h00);
    wr(ADDR_CTRL_ONE, 8'h01);
    tick(2);
    chk(programOneEn, 1'b0);
    rd(ADDR_CTRL_ONE, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h40);
    wr(ADDR_CTRL_TWO, 8'h01);
    tick(2);
    chk(programTwoEn, 1'b1);
    // every cpu event kind in turn
    for (int i = 0; i < 4; i++) begin
      doReset();
      wr(ADDR_CTRL_ONE, 8'h40);
      wr(ADDR_CTRL_ONE, 8'h41);
      tick(2);
      chk(programOneEn, 1'b1);
      @(posedge clock);
      cpuEvt <= fpep_cpu_evt_t'(4'h1 << i);
      @(posedge clock);
      cpuEvt <= '0;
      tick(2);
      chk(flashErrorFlag, 1'b1);
      chk(programOneEn, 1'b0);
      rd(ADDR_CTRL_ONE, 8'h41);
      rd(ADDR_CTRL_TWO, 8'h80);
      wr(ADDR_CTRL_ONE, 8'h41);
      tick(2);
      chk(programOneEn, 1'b0);
      wr(ADDR_CTRL_ONE, 8'h44);
      wr(ADDR_CTRL_TWO, 8'h08);
      tick(2);
      chk(programVerifyEn, 1'b1);
      chk(eraseVerifyEn, 1'b1);
      chk(flashErrorFlag, 1'b1);
      // software standby keeps the flag, hardware standby drops it
      for (int j = 0; j < 2; j++) begin
        @(posedge clock);
        swStandby <= (j == 0);
        hwStandby <= (j == 1);
        @(posedge clock);
        {swStandby, hwStandby} <= 2'b00;
        tick(2);
        chk(flashErrorFlag, 32'(j == 0));
        chk(programVerifyEn, 1'b0);
        chk(eraseVerifyEn, 1'b0);
      end
    end
    doReset();
    wr(ADDR_CTRL_ONE, 8'h40);
    wr(ADDR_CTRL_ONE, 8'h42);
    tick(2);
    chk(eraseBlockEn, 12'h000);
    wr(ADDR_ERASE_SEL_ONE, 8'h05);
    wr(ADDR_ERASE_SEL_TWO, 8'h10);
    wr(ADDR_CTRL_ONE, 8'h42);
    wr(ADDR_CTRL_TWO, 8'h02);
    tick(2);
    chk(eraseBlockEn, 12'h105);
    wr(ADDR_RAM_OVERLAY, 8'h05);
    tick(2);
    chk(overlayActive, 1'b1);
    chk(eraseBlockEn, 12'h000);
    acc(BLOCK_NINE_BASE + 32'h10, 1'b1);
    chk(accRoute.addr, RAM_BASE | 32'h10);
    acc(RAM_BASE + 32'h20, 1'b1);
    wr(ADDR_CTRL_ONE, 8'h41);
    tick(2);
    chk(programOneEn, 1'b0);
    wr(ADDR_RAM_OVERLAY, 8'h07);
    acc(BLOCK_NINE_BASE + 32'h800, 1'b1);
    acc(BLOCK_NINE_BASE + 32'h10, 1'b0);
    wr(ADDR_RAM_OVERLAY, 8'h00);
    tick(2);
    acc(BLOCK_NINE_BASE + 32'h10, 1'b0);
    wr(ADDR_CTRL_ONE, 8'h41);
    tick(2);
    chk(programOneEn, 1'b1);
    @(posedge clock);
    writeProtectPin <= 1'b1;
    tick(3);
    chk(programOneEn, 1'b0);
    rd(ADDR_ERASE_SEL_ONE, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h40);
    rd(ADDR_CTRL_ONE, 8'h00);
    reportAndStop();
  end
endmodule
